//--- logic/dcrc_pkg.sv
package dcrc_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h00;
  localparam logic [5:0] IDX_SETUP = 6'h02;
  localparam logic [5:0] IDX_DATA = 6'h04;
  localparam logic [5:0] IDX_RESULT = 6'h08;
  localparam logic [5:0] IDX_FLAGS = 6'h0c;
  localparam logic [5:0] IDX_HALT = 6'h0d;
  localparam logic [5:0] IDX_SERVICE = 6'h0e;
  localparam logic [5:0] IDX_SOFT = 6'h10;

  // Control register bits
  localparam int CTL_SOFT_RESET = 0;
  localparam int CTL_DMA_ENABLE = 1;
  localparam int CTL_CRC_ENABLE = 2;

  // Setup register fields
  localparam int SETUP_BEAT_LSB = 0;
  localparam int SETUP_POLY_LSB = 2;
  localparam int SETUP_SRC_LSB = 8;

  // Flag register bits
  localparam int FLAG_BUSY = 0;
  localparam int FLAG_ZERO = 1;

  // Service level field positions
  localparam int SVC_WB_LSB = 0;
  localparam int SVC_FETCH_LSB = 2;
  localparam int SVC_DATA_LSB = 4;

  localparam logic [7:0] SERVICE_RESET = 8'h15;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam int CHANNELS = 12;

  // Source codes
  localparam logic [5:0] SRC_NONE = 6'h00;
  localparam logic [5:0] SRC_BUS = 6'h01;

  // Polynomial codes and generators
  localparam logic [1:0] POLY_CRC16 = 2'h0;
  localparam logic [1:0] POLY_CRC32 = 2'h1;
  localparam logic [15:0] GEN_CRC16 = 16'h1021;
  localparam logic [31:0] GEN_CRC32 = 32'h04c1_1db7;

  // Beat size codes
  localparam logic [1:0] BEAT_BYTE = 2'h0;
  localparam logic [1:0] BEAT_HALF = 2'h1;
  localparam logic [1:0] BEAT_WORD = 2'h2;

  typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} dcrc_eng_state_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [5:0] idx;
  } dcrc_dphase_t;

  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [1:0] size;
    logic [31:0] data;
  } dcrc_beat_t;

endpackage : dcrc_pkg

//--- logic/dcrc_byte_step.sv
`timescale 1ns/10ps
// One byte of CRC, most significant data bit first
module dcrc_byte_step (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data_byte,
  input wire logic use_32,
  output logic [31:0] crc_out
);
  always_comb begin
    logic [31:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (use_32) begin
        fb = c[31] ^ data_byte[i];
        c = {c[30:0], 1'b0} ^ (fb ? dcrc_pkg::GEN_CRC32 : 32'h0000_0000);
      end else begin
        fb = c[15] ^ data_byte[i];
        c = {16'h0000, c[14:0], 1'b0} ^ {16'h0000, (fb ? dcrc_pkg::GEN_CRC16 : 16'h0000)};
      end
    end
    crc_out = c;
  end
endmodule : dcrc_byte_step

//--- logic/dcrc_engine.sv
`timescale 1ns/10ps
module dcrc_engine (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic debug_halt,
  input wire logic [11:0] channel_enabled,
  input wire logic [11:0] channel_request_pending,
  input wire dcrc_pkg::dcrc_beat_t chan_beat,
  output logic chan_beat_ready,
  output logic dma_enable,
  output logic crc_enable,
  output logic controller_halted,
  output logic [1:0] data_master_service,
  output logic [1:0] fetch_master_service,
  output logic [1:0] writeback_master_service,
  output logic [11:0] soft_request_pulse
);

  dcrc_pkg::dcrc_dphase_t dphase;
  dcrc_pkg::dcrc_eng_state_t eng_state;
  logic read_done;
  logic [5:0] crc_input_source;
  logic [1:0] polynomial_select;
  logic [1:0] input_beat_width;
  logic [31:0] crc_input_word;
  logic [31:0] crc_run;
  logic [31:0] shift_data;
  logic [2:0] bytes_left;
  logic crc_in_progress_flag;
  logic result_is_zero_flag;
  logic run_while_halted;
  logic [5:0] service;
  logic [11:0] channel_soft_request;
  logic chan_en_prev;

  wire addr_take = hsel & htrans[1] & hready;
  wire engine_running = (eng_state == dcrc_pkg::ENG_RUN);
  // Writes wait for the engine so a beat is never dropped mid-update
  wire write_stall = dphase.sel & dphase.write & engine_running;
  wire read_stall = dphase.sel & ~dphase.write & ~read_done;
  wire wr_ok = dphase.sel & dphase.write & ~engine_running;
  wire wr_control = wr_ok & (dphase.idx == dcrc_pkg::IDX_CONTROL);
  wire wr_setup = wr_ok & (dphase.idx == dcrc_pkg::IDX_SETUP);
  wire wr_data = wr_ok & (dphase.idx == dcrc_pkg::IDX_DATA);
  wire wr_result = wr_ok & (dphase.idx == dcrc_pkg::IDX_RESULT);
  wire wr_flags = wr_ok & (dphase.idx == dcrc_pkg::IDX_FLAGS);
  wire wr_halt = wr_ok & (dphase.idx == dcrc_pkg::IDX_HALT);
  wire wr_service = wr_ok & (dphase.idx == dcrc_pkg::IDX_SERVICE);
  wire wr_soft = wr_ok & (dphase.idx == dcrc_pkg::IDX_SOFT);

  wire soft_reset_hit = wr_control & hwdata[dcrc_pkg::CTL_SOFT_RESET] & ~dma_enable & ~crc_enable;
  wire halted = debug_halt & ~run_while_halted;
  wire use_32 = (polynomial_select == dcrc_pkg::POLY_CRC32);
  wire src_is_bus = (crc_input_source == dcrc_pkg::SRC_BUS);
  wire src_is_chan = crc_input_source[5];
  wire [4:0] src_chan = crc_input_source[4:0];
  wire sel_chan_en = src_is_chan & (src_chan < 5'd12) & channel_enabled[src_chan[3:0]];
  wire protect_ok = ~dma_enable;
  wire [5:0] new_source = hwdata[dcrc_pkg::SETUP_SRC_LSB +: 6];
  // Source stays locked while a run is in progress
  wire setup_take = wr_setup & protect_ok & ~crc_in_progress_flag;

  logic [2:0] beat_bytes;
  always_comb begin
    case (input_beat_width)
      dcrc_pkg::BEAT_BYTE: beat_bytes = 3'd1;
      dcrc_pkg::BEAT_HALF: beat_bytes = 3'd2;
      dcrc_pkg::BEAT_WORD: beat_bytes = 3'd4;
      default: beat_bytes = 3'd0;
    endcase
  end

  logic [2:0] chan_bytes;
  always_comb begin
    case (chan_beat.size)
      dcrc_pkg::BEAT_BYTE: chan_bytes = 3'd1;
      dcrc_pkg::BEAT_HALF: chan_bytes = 3'd2;
      dcrc_pkg::BEAT_WORD: chan_bytes = 3'd4;
      default: chan_bytes = 3'd0;
    endcase
  end

  wire bus_beat = wr_data & crc_enable & src_is_bus;
  wire chan_match = src_is_chan & ({1'b0, chan_beat.channel} == src_chan);
  assign chan_beat_ready = ~engine_running & ~halted & ~dphase.sel;
  wire chan_take = chan_beat.valid & chan_beat_ready & crc_enable & chan_match;

  logic [31:0] step_out;
  dcrc_byte_step u_step (
    .crc_in(crc_run),
    .data_byte(shift_data[7:0]),
    .use_32(use_32),
    .crc_out(step_out)
  );

  // Bit reversal of the running value for read, and of the write data for preset
  logic [31:0] run_rev;
  logic [31:0] wdata_rev;
  for (genvar b = 0; b < 32; b++) begin : g_rev
    assign run_rev[b] = crc_run[31 - b];
    assign wdata_rev[b] = hwdata[31 - b];
  end

  wire [31:0] result_view = use_32 ? run_rev : {16'h0000, crc_run[15:0]};
  wire result_zero = (result_view == dcrc_pkg::WORD_RESET);

  // Busy flag; a setting event wins over a clear in the same cycle
  logic next_busy;
  always_comb begin
    next_busy = crc_in_progress_flag;
    if (src_is_bus) begin
      if (wr_flags & hwdata[dcrc_pkg::FLAG_BUSY]) next_busy = 1'b0;
      if (bus_beat) next_busy = 1'b1;
    end else if (src_is_chan) begin
      if (chan_en_prev & ~sel_chan_en) next_busy = 1'b0;
      if (~chan_en_prev & sel_chan_en) next_busy = 1'b1;
    end
  end
  wire run_complete = crc_in_progress_flag & ~next_busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase <= '0;
    end else if (hready) begin
      dphase <= '{sel: addr_take, write: hwrite, idx: haddr[7:2]};
    end
  end

  logic [31:0] read_mux;
  always_comb begin
    read_mux = dcrc_pkg::WORD_RESET;
    case (dphase.idx)
      dcrc_pkg::IDX_CONTROL: read_mux = {29'h0, crc_enable, dma_enable, 1'b0};
      dcrc_pkg::IDX_SETUP: read_mux = {18'h0, crc_input_source, 4'h0, polynomial_select, input_beat_width};
      dcrc_pkg::IDX_DATA: read_mux = crc_input_word;
      dcrc_pkg::IDX_RESULT: read_mux = result_view;
      dcrc_pkg::IDX_FLAGS: read_mux = {30'h0, result_is_zero_flag, crc_in_progress_flag};
      dcrc_pkg::IDX_HALT: read_mux = {31'h0, run_while_halted};
      dcrc_pkg::IDX_SERVICE: read_mux = {26'h0, service};
      dcrc_pkg::IDX_SOFT: read_mux = {20'h0, channel_soft_request};
      default: read_mux = dcrc_pkg::WORD_RESET;
    endcase
  end

  // Reads always take one wait state so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= dcrc_pkg::WORD_RESET;
      read_done <= 1'b0;
    end else if (read_stall) begin
      hrdata <= read_mux;
      read_done <= 1'b1;
    end else begin
      read_done <= 1'b0;
    end
  end

  assign hreadyout = ~(write_stall | read_stall);
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_enable <= 1'b0;
      crc_enable <= 1'b0;
    end else if (soft_reset_hit) begin
      dma_enable <= 1'b0;
      crc_enable <= 1'b0;
    end else if (wr_control) begin
      dma_enable <= hwdata[dcrc_pkg::CTL_DMA_ENABLE];
      // A disable is refused while a run is in progress
      crc_enable <= hwdata[dcrc_pkg::CTL_CRC_ENABLE] | (crc_enable & crc_in_progress_flag);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_input_source <= dcrc_pkg::SRC_NONE;
      polynomial_select <= dcrc_pkg::POLY_CRC16;
      input_beat_width <= dcrc_pkg::BEAT_BYTE;
    end else if (soft_reset_hit) begin
      crc_input_source <= dcrc_pkg::SRC_NONE;
      polynomial_select <= dcrc_pkg::POLY_CRC16;
      input_beat_width <= dcrc_pkg::BEAT_BYTE;
    end else if (setup_take) begin
      crc_input_source <= new_source;
      polynomial_select <= hwdata[dcrc_pkg::SETUP_POLY_LSB +: 2];
      input_beat_width <= hwdata[dcrc_pkg::SETUP_BEAT_LSB +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_input_word <= dcrc_pkg::WORD_RESET;
    end else if (soft_reset_hit) begin
      crc_input_word <= dcrc_pkg::WORD_RESET;
    end else if (wr_data) begin
      crc_input_word <= hwdata;
    end
  end

  // Byte engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_state <= dcrc_pkg::ENG_IDLE;
      crc_run <= dcrc_pkg::WORD_RESET;
      shift_data <= dcrc_pkg::WORD_RESET;
      bytes_left <= 3'd0;
    end else if (soft_reset_hit) begin
      eng_state <= dcrc_pkg::ENG_IDLE;
      crc_run <= dcrc_pkg::WORD_RESET;
      shift_data <= dcrc_pkg::WORD_RESET;
      bytes_left <= 3'd0;
    end else begin
      case (eng_state)
        dcrc_pkg::ENG_IDLE: begin
          if (wr_result & protect_ok) begin
            crc_run <= use_32 ? wdata_rev : {16'h0000, hwdata[15:0]};
          end else if (bus_beat && beat_bytes != 3'd0) begin
            shift_data <= hwdata;
            bytes_left <= beat_bytes;
            eng_state <= dcrc_pkg::ENG_RUN;
          end else if (chan_take && chan_bytes != 3'd0) begin
            shift_data <= chan_beat.data;
            bytes_left <= chan_bytes;
            eng_state <= dcrc_pkg::ENG_RUN;
          end
        end
        dcrc_pkg::ENG_RUN: begin
          // Debug halt freezes the update mid-beat unless run_while_halted is set
          if (!halted) begin
            crc_run <= step_out;
            shift_data <= {8'h00, shift_data[31:8]};
            bytes_left <= bytes_left - 3'd1;
            if (bytes_left == 3'd1) eng_state <= dcrc_pkg::ENG_IDLE;
          end
        end
        default: eng_state <= dcrc_pkg::ENG_IDLE;
      endcase
    end
  end

  logic next_zero;
  always_comb begin
    next_zero = result_is_zero_flag;
    if (setup_take && new_source != crc_input_source) next_zero = 1'b0;
    if (run_complete & result_zero) next_zero = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_in_progress_flag <= 1'b0;
      result_is_zero_flag <= 1'b0;
      chan_en_prev <= 1'b0;
    end else if (soft_reset_hit) begin
      crc_in_progress_flag <= 1'b0;
      result_is_zero_flag <= 1'b0;
      chan_en_prev <= 1'b0;
    end else begin
      crc_in_progress_flag <= next_busy;
      result_is_zero_flag <= next_zero;
      chan_en_prev <= sel_chan_en;
    end
  end

  // Only a full reset or a halt-register write of zero clears the run bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_while_halted <= 1'b0;
    end else if (wr_halt) begin
      run_while_halted <= hwdata[0];
    end
  end
  assign controller_halted = halted;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      service <= dcrc_pkg::SERVICE_RESET[5:0];
    end else if (soft_reset_hit) begin
      service <= dcrc_pkg::SERVICE_RESET[5:0];
    end else if (wr_service & protect_ok) begin
      service <= hwdata[5:0];
    end
  end
  assign data_master_service = service[dcrc_pkg::SVC_DATA_LSB +: 2];
  assign fetch_master_service = service[dcrc_pkg::SVC_FETCH_LSB +: 2];
  assign writeback_master_service = service[dcrc_pkg::SVC_WB_LSB +: 2];

  // Trigger bits: write stores, a pending channel clears its bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_soft_request <= 12'h000;
      soft_request_pulse <= 12'h000;
    end else if (soft_reset_hit) begin
      channel_soft_request <= 12'h000;
      soft_request_pulse <= 12'h000;
    end else begin
      for (int ch = 0; ch < dcrc_pkg::CHANNELS; ch++) begin
        if (wr_soft) begin
          channel_soft_request[ch] <= hwdata[ch];
        end else if (channel_request_pending[ch]) begin
          channel_soft_request[ch] <= 1'b0;
        end
        soft_request_pulse[ch] <= wr_soft & hwdata[ch] & ~channel_request_pending[ch];
      end
    end
  end

endmodule : dcrc_engine

//--- verif/dcrc_engine_checker.sv
`timescale 1ns/10ps
module dcrc_engine_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic debug_halt,
  input wire logic [11:0] channel_request_pending,
  input wire logic chan_beat_ready,
  input wire logic dma_enable,
  input wire logic controller_halted,
  input wire logic [1:0] data_master_service,
  input wire logic [1:0] fetch_master_service,
  input wire logic [1:0] writeback_master_service,
  input wire logic [11:0] soft_request_pulse
);
  logic dp_wr;
  logic [5:0] dp_idx;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_idx <= 6'h00;
    end else if (hready) begin
      dp_wr <= hsel && htrans[1] && hwrite;
      dp_idx <= haddr[7:2];
    end
  end
  wire soft_wr = dp_wr && (dp_idx == dcrc_pkg::IDX_SOFT) && hready;
  wire [5:0] svc = {data_master_service, fetch_master_service, writeback_master_service};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence read_taken;
    hsel && htrans[1] && !hwrite && hready;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_one_wait: assert property (read_taken |=> one_wait)
    else $error("read wait state wrong");
  // A halt may stretch a stall without limit, so it ends the wait as well
  chk_stall_bounded: assert property (!hreadyout && !debug_halt |-> ##[1:4] (hreadyout || debug_halt))
    else $error("data phase stalled too long");
  chk_pulse_from_write: assert property (soft_request_pulse != 12'h000 |->
    $past(soft_wr) && (soft_request_pulse & ~$past(hwdata[11:0])) == 12'h000)
    else $error("trigger pulse without write");
  chk_pulse_not_pend: assert property (soft_request_pulse != 12'h000 |->
    (soft_request_pulse & $past(channel_request_pending)) == 12'h000)
    else $error("trigger pulse on pending channel");
  chk_halt_cause: assert property (controller_halted |-> debug_halt)
    else $error("halted without debugger");
  chk_halt_no_beat: assert property (controller_halted |-> !chan_beat_ready)
    else $error("beat accepted while halted");
  chk_svc_reset: assert property ($rose(hresetn) |-> svc == dcrc_pkg::SERVICE_RESET[5:0])
    else $error("service levels wrong after reset");
  chk_svc_protect: assert property ($changed(svc) |-> !$past(dma_enable))
    else $error("service level changed while enabled");
endmodule : dcrc_engine_checker

bind dcrc_engine dcrc_engine_checker i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .debug_halt, .channel_request_pending, .chan_beat_ready, .dma_enable,
  .controller_halted, .data_master_service, .fetch_master_service, .writeback_master_service,
  .soft_request_pulse);

//--- verif/dcrc_far_model.sv
`timescale 1ns/10ps
module dcrc_far_model (
  input wire logic hclk,
  input wire logic chan_beat_ready,
  output logic [11:0] channel_enabled,
  output logic [11:0] channel_request_pending,
  output dcrc_pkg::dcrc_beat_t chan_beat
);
  initial begin
    channel_enabled = 12'h000;
    channel_request_pending = 12'h000;
    chan_beat = '0;
  end
  task automatic set_lines(input logic [11:0] en, input logic [11:0] pend);
    @(posedge hclk);
    channel_enabled <= en;
    channel_request_pending <= pend;
  endtask : set_lines
  // Once taken the data shows its complement, so a stale beat never looks live
  task automatic send_beat(input logic [3:0] ch, input logic [31:0] d, input int slow);
    int n;
    n = 0;
    repeat (slow) @(posedge hclk);
    chan_beat <= '{valid: 1'b1, channel: ch, size: dcrc_pkg::BEAT_WORD, data: d};
    do begin
      @(posedge hclk);
      n++;
    end while (chan_beat_ready !== 1'b1 && n < 1000);
    if (n >= 1000) testbench.failures++;
    chan_beat <= '{valid: 1'b0, channel: ch, size: dcrc_pkg::BEAT_WORD, data: ~d};
  endtask : send_beat
endmodule : dcrc_far_model

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, debug_halt;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, svc_d, svc_f, svc_w;
  logic [2:0] hsize;
  logic [11:0] channel_enabled, channel_request_pending, soft_request_pulse;
  logic [11:0] pulse_seen = 12'h000;
  logic chan_beat_ready, dma_enable, crc_enable, controller_halted;
  dcrc_pkg::dcrc_beat_t chan_beat;
  int failures = 0;
  int samples_checked = 0;

  dcrc_engine i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .debug_halt, .channel_enabled, .channel_request_pending, .chan_beat,
    .chan_beat_ready, .dma_enable, .crc_enable, .controller_halted, .data_master_service(svc_d),
    .fetch_master_service(svc_f), .writeback_master_service(svc_w), .soft_request_pulse);
  dcrc_far_model i_far (.hclk, .chan_beat_ready, .channel_enabled, .channel_request_pending, .chan_beat);

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) pulse_seen <= pulse_seen | soft_request_pulse;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #120000;
    failures++;
    print_verdict();
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rc(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    check(rd, exp);
  endtask : rc
  // Non-reflected, most significant bit first, low byte first
  function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] d, input int n, input logic w);
    logic fb;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        fb = (w ? c[31] : c[15]) ^ d[8*b+i];
        c = c << 1;
        if (fb) c = c ^ (w ? dcrc_pkg::GEN_CRC32 : {16'h0000, dcrc_pkg::GEN_CRC16});
      end
    end
    return w ? {<<{c}} : {16'h0000, c[15:0]};
  endfunction : crc_ref

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    debug_halt = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rc(dcrc_pkg::IDX_DATA, 32'h0);
    rc(dcrc_pkg::IDX_RESULT, 32'h0);
    rc(dcrc_pkg::IDX_FLAGS, 32'h0);
    rc(dcrc_pkg::IDX_SERVICE, 32'h15);
    rc(dcrc_pkg::IDX_SOFT, 32'h0);
    rc(6'h3f, 32'h0);
    wr(dcrc_pkg::IDX_CONTROL, 32'h4);
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 3; s++) begin
        wr(dcrc_pkg::IDX_SETUP, {18'h0, dcrc_pkg::SRC_BUS, 4'h0, 2'(p), 2'(s)});
        wr(dcrc_pkg::IDX_RESULT, 32'hffff_ffff);
        wr(dcrc_pkg::IDX_DATA, 32'h9e3c_5a17);
        rc(dcrc_pkg::IDX_FLAGS, 32'h1);
        wr(dcrc_pkg::IDX_FLAGS, 32'h0);
        rc(dcrc_pkg::IDX_FLAGS, 32'h1);
        wr(dcrc_pkg::IDX_FLAGS, 32'h1);
        rc(dcrc_pkg::IDX_FLAGS, 32'h0);
        rc(dcrc_pkg::IDX_RESULT, crc_ref(32'hffff_ffff, 32'h9e3c_5a17, 1 << s, p[0]));
      end
    end
    // Reserved beat size: busy still set, running value untouched
    wr(dcrc_pkg::IDX_SETUP, {18'h0, dcrc_pkg::SRC_BUS, 4'h0, dcrc_pkg::POLY_CRC32, 2'h3});
    wr(dcrc_pkg::IDX_RESULT, 32'h1234_5678);
    wr(dcrc_pkg::IDX_DATA, 32'h9e3c_5a17);
    rc(dcrc_pkg::IDX_FLAGS, 32'h1);
    wr(dcrc_pkg::IDX_FLAGS, 32'h1);
    rc(dcrc_pkg::IDX_RESULT, 32'h1234_5678);
    wr(dcrc_pkg::IDX_RESULT, 32'h0);
    wr(dcrc_pkg::IDX_DATA, 32'h0);
    wr(dcrc_pkg::IDX_FLAGS, 32'h1);
    rc(dcrc_pkg::IDX_FLAGS, 32'h2);
    wr(dcrc_pkg::IDX_SETUP, {18'h0, 6'h20, 8'h04});
    rc(dcrc_pkg::IDX_FLAGS, 32'h0);
    i_far.set_lines(12'h001, 12'h000);
    rc(dcrc_pkg::IDX_FLAGS, 32'h1);
    wr(dcrc_pkg::IDX_FLAGS, 32'h1);
    rc(dcrc_pkg::IDX_FLAGS, 32'h1);
    i_far.send_beat(4'h0, 32'hc0ff_ee11, 3);
    i_far.set_lines(12'h000, 12'h000);
    rc(dcrc_pkg::IDX_FLAGS, 32'h0);
    rc(dcrc_pkg::IDX_RESULT, crc_ref(32'h0, 32'hc0ff_ee11, 4, 1'b1));
    wr(dcrc_pkg::IDX_CONTROL, 32'h2);
    wr(dcrc_pkg::IDX_SERVICE, 32'h1b);
    rc(dcrc_pkg::IDX_SERVICE, 32'h15);
    check({30'h0, crc_enable, dma_enable}, 32'h1);
    check({31'h0, hresp}, 32'h0);
    wr(dcrc_pkg::IDX_CONTROL, 32'h0);
    wr(dcrc_pkg::IDX_SERVICE, 32'h1b);
    rc(dcrc_pkg::IDX_SERVICE, 32'h1b);
    check({26'h0, svc_d, svc_f, svc_w}, 32'h1b);
    wr(dcrc_pkg::IDX_HALT, 32'h1);
    wr(dcrc_pkg::IDX_CONTROL, 32'h1);
    rc(dcrc_pkg::IDX_HALT, 32'h1);
    rc(dcrc_pkg::IDX_SERVICE, 32'h15);
    debug_halt <= 1'b1;
    @(posedge hclk);
    check({31'h0, controller_halted}, 32'h0);
    wr(dcrc_pkg::IDX_HALT, 32'h0);
    // The run bit updates at the edge that ends the write
    @(posedge hclk);
    check({31'h0, controller_halted}, 32'h1);
    debug_halt <= 1'b0;
    i_far.set_lines(12'h000, 12'h008);
    wr(dcrc_pkg::IDX_SOFT, 32'h9);
    repeat (2) @(posedge hclk);
    check({20'h0, pulse_seen}, 32'h1);
    i_far.set_lines(12'h000, 12'hfff);
    rc(dcrc_pkg::IDX_SOFT, 32'h0);
    print_verdict();
  end
endmodule : testbench
